// [verilog/link_cs_pkg.sv]
// constants shared by the link control and status register logic
package link_cs_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] LINK_REG_ADDR = 8'hD0;
    localparam int ASPM_LSB = 0;
    localparam int RCB_BIT = 3;
    localparam int DIS_BIT = 4;
    localparam int RETRAIN_BIT = 5;
    localparam int CCLK_BIT = 6;
    localparam int EXTS_BIT = 7;
    localparam int HAWD_BIT = 9;
    localparam int B10_BIT = 10;
    localparam int B11_BIT = 11;
    localparam int SPEED_LSB = 16;
    localparam int WIDTH_LSB = 20;
    localparam int TERR_BIT = 26;
    localparam int LTRN_BIT = 27;
    localparam int SCLK_BIT = 28;
    localparam int DLA_BIT = 29;
    localparam logic [1:0] ASPM_RST = 2'h0;
    localparam logic [1:0] ASPM_L0S = 2'h1;
    localparam logic [1:0] ASPM_L1 = 2'h2;
    localparam logic [1:0] ASPM_BOTH = 2'h3;
    localparam logic [3:0] SPEED_2G5 = 4'h1;
    localparam logic [3:0] SPEED_5G0 = 4'h2;
    localparam logic [3:0] SPEED_RST = 4'h2;
    localparam logic [5:0] WIDTH_RST = 6'h01;
    localparam logic [12:0] FTS_EXT = 13'h1000;
    localparam logic [12:0] FTS_NORM = 13'h00FF;
    localparam logic [10:0] TS1_EXT = 11'h400;
    localparam logic [10:0] TS1_NORM = 11'h010;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

// [verilog/reg_req_if.sv]
// register request carrier between bus slave and register bank
`timescale 1ns/100ps
interface reg_req_if;
    logic wr_en;
    logic [7:0] waddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic whit;
    logic [7:0] raddr;
    logic [31:0] rdata;
    logic rhit;
    modport bus (output wr_en, waddr, wdata, wstrb, raddr, input whit, rdata, rhit);
    modport regs (input wr_en, waddr, wdata, wstrb, raddr, output whit, rdata, rhit);
endinterface

// [verilog/axil_slave.sv]
// axi4-lite slave front end, one write and one read at a time
`timescale 1ns/100ps
module axil_slave (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    reg_req_if.bus rq
);
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axs_t;
    axs_t q, d;

    // write goes once both halves are held and the old response is gone
    assign awready = !q.aw_full && !q.bvalid;
    assign wready = !q.w_full && !q.bvalid;
    assign arready = !q.rvalid;
    assign rq.wr_en = q.aw_full && q.w_full && !q.bvalid;
    assign rq.waddr = q.aw_addr;
    assign rq.wdata = q.w_data;
    assign rq.wstrb = q.w_strb;
    assign rq.raddr = araddr;
    assign bvalid = q.bvalid;
    assign bresp = q.bresp;
    assign rvalid = q.rvalid;
    assign rdata = q.rdata;
    assign rresp = q.rresp;

    always_comb begin
        d = q;
        if (awvalid && awready) begin
            d.aw_full = 1'b1;
            d.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            d.w_full = 1'b1;
            d.w_data = wdata;
            d.w_strb = wstrb;
        end
        if (rq.wr_en) begin
            d.aw_full = 1'b0;
            d.w_full = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = rq.whit ? link_cs_pkg::RESP_OKAY : link_cs_pkg::RESP_DECERR;
        end else if (q.bvalid && bready) begin
            d.bvalid = 1'b0;
        end
        if (arvalid && arready) begin
            d.rvalid = 1'b1;
            d.rdata = rq.rhit ? rq.rdata : 32'h0000_0000;
            d.rresp = rq.rhit ? link_cs_pkg::RESP_OKAY : link_cs_pkg::RESP_DECERR;
        end else if (q.rvalid && rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end
endmodule

// [verilog/link_train_tracker.sv]
// training progress, training error, negotiated speed and width
`timescale 1ns/100ps
module link_train_tracker #(
    parameter int WIDTH_W = 6
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic retrain_go,
    input wire logic training,
    input wire logic train_fail,
    input wire logic train_done,
    input wire logic [3:0] neg_speed,
    input wire logic [WIDTH_W-1:0] neg_width,
    output logic lnk_training,
    output logic train_error,
    output logic [3:0] speed,
    output logic [WIDTH_W-1:0] width
);
    typedef struct packed {
        logic trn;
        logic err;
        logic [3:0] speed;
        logic [WIDTH_W-1:0] width;
    } trk_t;
    trk_t q, d;

    always_comb begin
        d = q;
        // a new request wins over the completion seen in the same cycle
        // a failed attempt ends training too, so the flag must not stick after it
        d.trn = retrain_go || training || (q.trn && !train_done && !train_fail);
        d.err = train_fail || (q.err && !train_done);
        if (train_done) begin
            d.speed = neg_speed;
            d.width = neg_width;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{trn: 1'b0, err: 1'b0, speed: link_cs_pkg::SPEED_RST,
                   width: WIDTH_W'(link_cs_pkg::WIDTH_RST)};
        end else begin
            q <= d;
        end
    end

    assign lnk_training = q.trn;
    assign train_error = q.err;
    assign speed = q.speed;
    assign width = q.width;
endmodule

// [verilog/link_ctl_status.sv]
// link control and link status register bank of one switch port
//
// Register access over AXI4-Lite is this design's own decision.
`timescale 1ns/100ps
module link_ctl_status #(
    parameter bit UPSTREAM = 1'b0
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ltssm_training,
    input wire logic ltssm_train_fail,
    input wire logic ltssm_train_done,
    input wire logic dl_active,
    input wire logic [3:0] neg_speed,
    input wire logic [5:0] neg_width,
    input wire logic slot_clock_strap,
    output logic aspm_l0s_en,
    output logic aspm_l1_en,
    output logic rx_l0s_capable,
    output logic link_disable,
    output logic retrain_start,
    output logic common_clock,
    output logic ext_synch,
    output logic [12:0] fts_exit_count,
    output logic [10:0] ts1_exit_count,
    output logic hw_width_disable,
    output logic ctl_bit10,
    output logic ctl_bit11
);
    // --------------------------------------------------------------
    // state
    // --------------------------------------------------------------
    typedef struct packed {
        logic [1:0] aspm;
        logic dis;
        logic cclk;
        logic exts;
        logic hawd;
        logic b10;
        logic b11;
        logic retrain;
        logic [1:0] strap_sync;
        logic [1:0] settle;
        logic slot_clk;
        logic dla;
    } ctl_t;
    ctl_t q, d;

    reg_req_if rq ();

    logic lnk_training;
    logic train_error;
    logic [3:0] speed;
    logic [5:0] width;
    logic wr_lo;
    logic retrain_go;

    // --------------------------------------------------------------
    // bus front end
    // --------------------------------------------------------------
    axil_slave u_axil (
        .aclk(aclk),
        .aresetn(aresetn),
        .awaddr(s_axi_awaddr),
        .awvalid(s_axi_awvalid),
        .awready(s_axi_awready),
        .wdata(s_axi_wdata),
        .wstrb(s_axi_wstrb),
        .wvalid(s_axi_wvalid),
        .wready(s_axi_wready),
        .bresp(s_axi_bresp),
        .bvalid(s_axi_bvalid),
        .bready(s_axi_bready),
        .araddr(s_axi_araddr),
        .arvalid(s_axi_arvalid),
        .arready(s_axi_arready),
        .rdata(s_axi_rdata),
        .rresp(s_axi_rresp),
        .rvalid(s_axi_rvalid),
        .rready(s_axi_rready),
        .rq(rq)
    );

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[7:2] == link_cs_pkg::LINK_REG_ADDR[7:2]);
    endfunction

    // status halfword only ever reads; control halfword on byte lanes 0, 1
    assign rq.whit = addr_hit(rq.waddr);
    assign rq.rhit = addr_hit(rq.raddr);
    assign wr_lo = rq.wr_en && rq.whit;
    assign retrain_go = !UPSTREAM && wr_lo && rq.wstrb[0]
                        && rq.wdata[link_cs_pkg::RETRAIN_BIT];

    // --------------------------------------------------------------
    // training status
    // --------------------------------------------------------------
    link_train_tracker #(
        .WIDTH_W(6)
    ) u_trk (
        .aclk(aclk),
        .aresetn(aresetn),
        .retrain_go(retrain_go),
        .training(ltssm_training),
        .train_fail(ltssm_train_fail),
        .train_done(ltssm_train_done),
        .neg_speed(neg_speed),
        .neg_width(neg_width),
        .lnk_training(lnk_training),
        .train_error(train_error),
        .speed(speed),
        .width(width)
    );

    // --------------------------------------------------------------
    // control register update
    // --------------------------------------------------------------
    always_comb begin
        d = q;
        d.retrain = retrain_go;
        // strap is a pin: two flops, then sampled on the first three cycles after reset and held
        d.strap_sync = {q.strap_sync[0], slot_clock_strap};
        if (q.settle != 2'h3) begin
            d.settle = q.settle + 2'h1;
            d.slot_clk = q.strap_sync[1];
        end
        d.dla = dl_active;
        if (wr_lo && rq.wstrb[0]) begin
            d.aspm = rq.wdata[link_cs_pkg::ASPM_LSB +: 2];
            d.dis = !UPSTREAM && rq.wdata[link_cs_pkg::DIS_BIT];
            d.cclk = rq.wdata[link_cs_pkg::CCLK_BIT];
            d.exts = rq.wdata[link_cs_pkg::EXTS_BIT];
        end
        if (wr_lo && rq.wstrb[1]) begin
            d.hawd = rq.wdata[link_cs_pkg::HAWD_BIT];
            d.b10 = !UPSTREAM && rq.wdata[link_cs_pkg::B10_BIT];
            d.b11 = !UPSTREAM && rq.wdata[link_cs_pkg::B11_BIT];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '{aspm: link_cs_pkg::ASPM_RST, default: '0};
        end else begin
            q <= d;
        end
    end

    // --------------------------------------------------------------
    // read word
    // --------------------------------------------------------------
    // rcb, retrain and reserved positions stay zero
    always_comb begin
        rq.rdata = 32'h0000_0000;
        rq.rdata[link_cs_pkg::ASPM_LSB +: 2] = q.aspm;
        rq.rdata[link_cs_pkg::DIS_BIT] = q.dis;
        rq.rdata[link_cs_pkg::CCLK_BIT] = q.cclk;
        rq.rdata[link_cs_pkg::EXTS_BIT] = q.exts;
        rq.rdata[link_cs_pkg::HAWD_BIT] = q.hawd;
        rq.rdata[link_cs_pkg::B10_BIT] = q.b10;
        rq.rdata[link_cs_pkg::B11_BIT] = q.b11;
        rq.rdata[link_cs_pkg::SPEED_LSB +: 4] = speed;
        rq.rdata[link_cs_pkg::WIDTH_LSB +: 6] = width;
        rq.rdata[link_cs_pkg::TERR_BIT] = train_error;
        rq.rdata[link_cs_pkg::LTRN_BIT] = lnk_training;
        rq.rdata[link_cs_pkg::SCLK_BIT] = q.slot_clk;
        rq.rdata[link_cs_pkg::DLA_BIT] = q.dla;
    end

    // --------------------------------------------------------------
    // outputs to link training and power management
    // --------------------------------------------------------------
    assign aspm_l0s_en = q.aspm[0];
    assign aspm_l1_en = q.aspm[1];
    assign rx_l0s_capable = 1'b1;
    assign link_disable = q.dis;
    assign retrain_start = q.retrain;
    assign common_clock = q.cclk;
    assign ext_synch = q.exts;
    assign fts_exit_count = q.exts ? link_cs_pkg::FTS_EXT : link_cs_pkg::FTS_NORM;
    assign ts1_exit_count = q.exts ? link_cs_pkg::TS1_EXT : link_cs_pkg::TS1_NORM;
    assign hw_width_disable = q.hawd;
    assign ctl_bit10 = q.b10;
    assign ctl_bit11 = q.b11;

    // --------------------------------------------------------------
    // checks
    // --------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_ctl_wr;
        wr_lo && rq.wstrb[0];
    endsequence

    sequence s_retrain_wr;
        retrain_go;
    endsequence

    property p_aspm_wr;
        s_ctl_wr |=> ({aspm_l1_en, aspm_l0s_en} == $past(rq.wdata[1:0]));
    endproperty
    a_aspm_wr: assert property (p_aspm_wr) else $error("aspm enables wrong after write");

    property p_l0s_rx;
        (q.aspm == link_cs_pkg::ASPM_RST) |-> rx_l0s_capable;
    endproperty
    a_l0s_rx: assert property (p_l0s_rx) else $error("receiver lost L0s capability");

    property p_rd_zero;
        s_axi_rvalid |-> (s_axi_rdata[link_cs_pkg::RCB_BIT] == 1'b0)
                         && (s_axi_rdata[link_cs_pkg::RETRAIN_BIT] == 1'b0)
                         && (s_axi_rdata[15:12] == 4'h0) && (s_axi_rdata[31:30] == 2'h0);
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("fixed zero bit read as one");

    property p_dis;
        s_ctl_wr |=> (link_disable == (!UPSTREAM && $past(rq.wdata[link_cs_pkg::DIS_BIT])));
    endproperty
    a_dis: assert property (p_dis) else $error("link disable wrong after write");

    property p_retrain;
        s_retrain_wr |=> retrain_start && lnk_training ##1 !retrain_start;
    endproperty
    a_retrain: assert property (p_retrain) else $error("retrain not started or flag not set");

    property p_ext;
        ext_synch |-> (fts_exit_count == 13'h1000) && (ts1_exit_count == 11'h400);
    endproperty
    a_ext: assert property (p_ext) else $error("extended synch counts wrong");

    property p_up_zero;
        UPSTREAM |-> !ctl_bit10 && !ctl_bit11 && !link_disable && !retrain_start;
    endproperty
    a_up_zero: assert property (p_up_zero) else $error("upstream hardwired bit set");

    property p_terr;
        ltssm_train_fail |=> train_error;
    endproperty
    a_terr: assert property (p_terr) else $error("training error not flagged");

    property p_terr_clr;
        ltssm_train_done && !ltssm_train_fail |=> !train_error;
    endproperty
    a_terr_clr: assert property (p_terr_clr) else $error("training error not cleared in L0");

    property p_dla;
        1'b1 |=> (rq.rdata[link_cs_pkg::DLA_BIT] == $past(dl_active));
    endproperty
    a_dla: assert property (p_dla) else $error("link active flag missing");

    property p_trn;
        ltssm_training |=> lnk_training;
    endproperty
    a_trn: assert property (p_trn) else $error("training flag not set");
endmodule

// [verif/link_partner_model.sv]
// far-side link trainer model driving training and data link status
`timescale 1ns/100ps
module link_partner_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic retrain_start,
    input wire logic link_disable,
    input wire logic train_go,
    input wire logic fail_mode,
    input wire logic slow,
    input wire logic [3:0] speed_in,
    input wire logic [5:0] width_in,
    output logic ltssm_training,
    output logic ltssm_train_fail,
    output logic ltssm_train_done,
    output logic dl_active,
    output logic [3:0] neg_speed,
    output logic [5:0] neg_width
);
    int cnt;
    always @(posedge aclk) begin
        ltssm_train_fail <= 1'h0;
        ltssm_train_done <= 1'h0;
        // negotiated values only mean something with done, so keep them moving
        neg_speed <= ~neg_speed;
        neg_width <= ~neg_width;
        if (!aresetn) begin
            ltssm_training <= 1'h0;
            dl_active <= 1'h0;
            neg_speed <= 4'h5;
            neg_width <= 6'h2A;
        end else if (link_disable) begin
            ltssm_training <= 1'h0;
            dl_active <= 1'h0;
        end else if (retrain_start || train_go) begin
            ltssm_training <= 1'h1;
            dl_active <= 1'h0;
            cnt <= slow ? 12 : 3;
        end else if (ltssm_training) begin
            cnt <= cnt - 1;
            if (cnt == 1) begin
                ltssm_training <= 1'h0;
                ltssm_train_fail <= fail_mode;
                ltssm_train_done <= !fail_mode;
                dl_active <= !fail_mode;
                neg_speed <= speed_in;
                neg_width <= width_in;
            end
        end
    end
endmodule

// [verif/tb_top.sv]
// self-checking bench for the link control and status register bank
`timescale 1ns/100ps
module tb_top;
    logic aclk = 1'h0;
    logic aresetn = 1'h0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata, up_rdata;
    logic ltssm_training, ltssm_train_fail, ltssm_train_done, dl_active;
    logic slot_clock_strap = 1'h0, train_go = 1'h0, fail_mode = 1'h0, slow = 1'h1;
    logic [2:0] prot = 3'h0;
    logic [3:0] neg_speed, speed_in = 4'h2;
    logic [5:0] neg_width, width_in = 6'h01;
    logic aspm_l0s_en, aspm_l1_en, rx_l0s_capable, link_disable, retrain_start, common_clock, ext_synch;
    logic hw_width_disable, ctl_bit10, ctl_bit11, up_ldis, up_rtr;
    logic [12:0] fts_exit_count;
    logic [10:0] ts1_exit_count;
    int failures = 0, cmp_count = 0, rtr_dn = 0, rtr_up = 0;

    link_ctl_status #(.UPSTREAM(1'b0)) i_dut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .ltssm_training, .ltssm_train_fail, .ltssm_train_done, .dl_active, .neg_speed, .neg_width,
        .slot_clock_strap, .aspm_l0s_en, .aspm_l1_en, .rx_l0s_capable, .link_disable, .retrain_start,
        .common_clock, .ext_synch, .fts_exit_count, .ts1_exit_count, .hw_width_disable, .ctl_bit10, .ctl_bit11);

    // upstream copy shares every input except awprot and arprot (driven from prot, not 0) and follows the same bus timing
    link_ctl_status #(.UPSTREAM(1'b1)) i_dut_up (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(prot), .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(), .s_axi_bready,
        .s_axi_araddr, .s_axi_arprot(prot), .s_axi_arvalid, .s_axi_arready(), .s_axi_rdata(up_rdata),
        .s_axi_rresp(), .s_axi_rvalid(), .s_axi_rready, .ltssm_training, .ltssm_train_fail, .ltssm_train_done,
        .dl_active, .neg_speed, .neg_width, .slot_clock_strap, .aspm_l0s_en(), .aspm_l1_en(),
        .rx_l0s_capable(), .link_disable(up_ldis), .retrain_start(up_rtr), .common_clock(), .ext_synch(),
        .fts_exit_count(), .ts1_exit_count(), .hw_width_disable(), .ctl_bit10(), .ctl_bit11());

    link_partner_model i_partner (
        .aclk, .aresetn, .retrain_start, .link_disable, .train_go, .fail_mode, .slow, .speed_in, .width_in,
        .ltssm_training, .ltssm_train_fail, .ltssm_train_done, .dl_active, .neg_speed, .neg_width);

    always #10 aclk = ~aclk;

    always @(posedge aclk) begin
        if (retrain_start === 1'h1)
            rtr_dn++;
        if (up_rtr === 1'h1)
            rtr_up++;
    end

    // ----------------------------------------
    // checking and expectations
    // ----------------------------------------
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", name, exp, got);
        end
    endtask

    function automatic logic [15:0] next_ctl(input logic [15:0] c, input logic [31:0] d, input logic [3:0] s,
                                            input logic up);
        logic [15:0] m;
        m = up ? 16'h02C3 : 16'h0ED3;
        if (!s[0])
            m[7:0] = 8'h00;
        if (!s[1])
            m[15:8] = 8'h00;
        return (c & ~m) | (d[15:0] & m);
    endfunction

    function automatic logic [15:0] st(input logic [3:0] sp, input logic [5:0] wd, input logic er, input logic tr,
                                       input logic dla);
        return {2'h0, dla, slot_clock_strap, tr, er, wd, sp};
    endfunction

    function automatic logic [31:0] exp_out(input logic [15:0] c);
        return {c[7] ? link_cs_pkg::FTS_EXT : link_cs_pkg::FTS_NORM, c[7] ? link_cs_pkg::TS1_EXT : link_cs_pkg::TS1_NORM,
                c[11], c[10], c[9], c[7], c[6], c[4], c[1], c[0]};
    endfunction

    // ----------------------------------------
    // bus master tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        logic ap, wp;
        int n;
        ap = 1'h1;
        wp = 1'h1;
        n = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        prot <= 3'($urandom);
        while ((ap || wp) && n < 50) begin
            @(posedge aclk);
            n++;
            if (ap && s_axi_awready) begin
                ap = 1'h0;
                s_axi_awvalid <= 1'h0;
            end
            if (wp && s_axi_wready) begin
                wp = 1'h0;
                s_axi_wvalid <= 1'h0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_bvalid !== 1'h1 && n < 50);
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 50)
            chk("write timeout", 32'h0, 32'h1);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [31:0] u, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_arready !== 1'h1 && n < 50);
        s_axi_arvalid <= 1'h0;
        do begin
            @(posedge aclk);
            n++;
        end while (s_axi_rvalid !== 1'h1 && n < 50);
        d = s_axi_rdata;
        u = up_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 50)
            chk("read timeout", 32'h0, 32'h1);
    endtask

    initial begin
        #100000;
        failures++;
        end_of_test();
    end

    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        logic [31:0] d, u, seed;
        logic [15:0] cd, cu;
        logic [3:0] s;
        logic [1:0] r;
        seed = $urandom(11);
        cd = 16'h0;
        cu = 16'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("reset dn", {st(4'h2, 6'h01, 1'h0, 1'h0, 1'h0), 16'h0}, d);
        chk("reset up", {st(4'h2, 6'h01, 1'h0, 1'h0, 1'h0), 16'h0}, u);
        // first four writes walk every aspm code, then random words and strobes
        for (int i = 0; i < 24; i++) begin
            d = (i < 4) ? 32'(i) : $urandom;
            d[5] = 1'h0;
            s = (i < 4) ? 4'h1 : 4'($urandom);
            wr(8'hD0, d, s, r);
            chk("write resp", 32'h0, 32'(r));
            cd = next_ctl(cd, d, s, 1'h0);
            cu = next_ctl(cu, d, s, 1'h1);
            rd(8'hD0, d, u, r);
            chk("control dn", {st(4'h2, 6'h01, 1'h0, 1'h0, 1'h0), cd}, d);
            chk("control up", {16'h0, cu}, {16'h0, u[15:0]});
            chk("outputs", exp_out(cd), {fts_exit_count, ts1_exit_count, ctl_bit11, ctl_bit10, hw_width_disable,
                ext_synch, common_clock, link_disable, aspm_l1_en, aspm_l0s_en});
            chk("rx l0s", 32'h1, 32'(rx_l0s_capable));
            chk("up disable", 32'h0, 32'(up_ldis));
        end
        wr(8'hD4, 32'hFFFF, 4'hF, r);
        chk("unmapped bresp", 32'h3, 32'(r));
        rd(8'hD4, d, u, r);
        chk("unmapped rdata", 32'h0, d);
        chk("unmapped rresp", 32'h3, 32'(r));
        rd(8'hD0, d, u, r);
        chk("kept control", {16'h0, cd}, {16'h0, d[15:0]});
        wr(8'hD0, 32'h0, 4'h3, r);
        speed_in <= 4'h1;
        width_in <= 6'($urandom_range(1, 16));
        wr(8'hD0, 32'h20, 4'h1, r);
        rd(8'hD0, d, u, r);
        chk("retrain start", {st(4'h2, 6'h01, 1'h0, 1'h1, 1'h0), 16'h0}, d);
        repeat (20) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("retrain end", {st(speed_in, width_in, 1'h0, 1'h0, 1'h1), 16'h0}, d);
        fail_mode <= 1'h1;
        slow <= 1'h0;
        train_go <= 1'h1;
        @(posedge aclk);
        train_go <= 1'h0;
        repeat (10) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("train fail", {st(speed_in, width_in, 1'h1, 1'h0, 1'h0), 16'h0}, d);
        fail_mode <= 1'h0;
        wr(8'hD0, 32'h20, 4'h1, r);
        repeat (20) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("error cleared", {st(speed_in, width_in, 1'h0, 1'h0, 1'h1), 16'h0}, d);
        chk("retrain pulses dn", 32'h2, 32'(rtr_dn));
        chk("retrain pulses up", 32'h0, 32'(rtr_up));
        wr(8'hD0, 32'h10, 4'h1, r);
        repeat (3) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("disabled", {st(speed_in, width_in, 1'h0, 1'h0, 1'h0), 16'h0010}, d);
        chk("disable up", 32'h0, {16'h0, u[15:0]});
        // second reset in mid-run with the strap flipped: control clears, slot clock takes the new strap
        slot_clock_strap <= 1'h1;
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'h1;
        repeat (4) @(posedge aclk);
        rd(8'hD0, d, u, r);
        chk("rereset dn", {st(4'h2, 6'h01, 1'h0, 1'h0, 1'h0), 16'h0}, d);
        chk("rereset up", {st(4'h2, 6'h01, 1'h0, 1'h0, 1'h0), 16'h0}, u);
        chk("rereset disable", 32'h0, 32'(link_disable));
        end_of_test();
    end
endmodule
